// ==== can_timing_pkg.sv ====
// Package for the CAN bit-timing and interrupt-vector block.
// Assumes one clock domain; shared by the design and the bench.
package can_timing_pkg;

	// Register byte addresses on the Avalon-MM slave.
	localparam logic [3:0] ADDR_TIMING   = 4'h0;
	localparam logic [3:0] ADDR_VECTOR   = 4'h4;
	localparam logic [3:0] ADDR_CONTROL  = 4'h8;
	localparam logic [3:0] ADDR_STATUS   = 4'hC;
	localparam logic [3:0] ADDR_MASK     = 4'h0;
	localparam logic [3:0] ADDR_TIMEOUT  = 4'h0;

	// Timing register fields.
	localparam int WAKE_BIT   = 22;
	localparam int PH2_HI     = 18;
	localparam int PH2_LO     = 16;
	localparam int FREE_BIT   = 15;
	localparam int TRIPLE_BIT = 14;
	localparam int PH1_HI     = 13;
	localparam int PH1_LO     = 11;
	localparam int PROP_HI    = 10;
	localparam int PROP_LO    = 8;
	localparam int SJW_HI     = 7;
	localparam int SJW_LO     = 6;
	localparam int BRP_HI     = 5;
	localparam int BRP_LO     = 0;
	localparam logic [31:0] TIMING_WMASK = 32'h0047FFFF;

	// Control register: operating mode at 23..21.
	localparam int MODE_HI = 23;
	localparam int MODE_LO = 21;
	localparam logic [2:0] MODE_CONFIG = 3'h4;
	localparam logic [2:0] MODE_RESET  = 3'h4;

	// Vector register fields.
	localparam int FILT_HI = 12;
	localparam int FILT_LO = 8;
	localparam int CODE_HI = 6;

	// Interrupt cause codes.
	localparam logic [6:0] CODE_NONE     = 7'h40;
	localparam logic [6:0] CODE_ERROR    = 7'h41;
	localparam logic [6:0] CODE_WAKE     = 7'h42;
	localparam logic [6:0] CODE_OVERFLOW = 7'h43;
	localparam logic [6:0] CODE_ADDR     = 7'h44;
	localparam logic [6:0] CODE_BANDW    = 7'h45;
	localparam logic [6:0] CODE_TIMER    = 7'h46;
	localparam logic [6:0] CODE_MODE     = 7'h47;
	localparam logic [6:0] CODE_INVALID  = 7'h48;

	// Information processing time in quanta, and the triple-sample floor.
	localparam logic [3:0] IPT_QUANTA  = 4'h2;
	localparam logic [5:0] BRP_MIN_TRI = 6'h02;

	// Event sources, one sticky status bit each.
	typedef struct packed {
		logic invalid_message_flag;
		logic mode_change_flag;
		logic timestamp_timer_flag;
		logic bandwidth_error;
		logic system_error_flag;
		logic receive_overflow_flag;
		logic wakeup_flag;
		logic bus_error_flag;
	} event_s;

	// Decoded bit timing offered to the bit engine.
	typedef struct packed {
		logic [3:0] phase_one_length;
		logic [3:0] phase_two_length;
		logic [3:0] propagation_segment;
		logic [1:0] resync_jump_width;
		logic [5:0] baud_prescaler;
		logic       triple_sample_select;
		logic       wakeup_line_filter_enable;
	} timing_s;

endpackage : can_timing_pkg

// ==== can_bit_timing_and_vector.sv ====
// Bit-timing configuration, sampling, wake filter and interrupt vector.
// Assumes an Avalon-MM master on mclk and bus pins from the transceiver.
`timescale 1ns/100ps
module can_bit_timing_and_vector #(
	parameter int FIFOS = 16
) (
	input  wire logic                        mclk,
	input  wire logic                        rst,
	input  wire logic [3:0]                  address,
	input  wire logic                        read,
	input  wire logic                        write,
	input  wire logic [31:0]                 writedata,
	output logic [31:0]                      readdata,
	output logic                             waitrequest,
	input  wire logic                        bus_rx,
	input  wire logic                        sample_point,
	input  wire logic [FIFOS-1:0]            fifo_status_flags,
	input  wire logic [4:0]                  matched_filter_number,
	input  wire logic                        filter_match,
	input  wire can_timing_pkg::event_s      event_pulse,
	output can_timing_pkg::timing_s          timing,
	output logic                             sampled_bit,
	output logic                             wake_line,
	output logic                             irq
);

	// Bus handshake: waitrequest is high while idle and falls for exactly
	// one clock per access, at the edge that first sees the request.
	// answered is high exactly while waitrequest is low, so it marks the
	// edge at which the master takes the answer.
	// A master may raise its next request right at that edge; it is seen
	// one clock later and answered in the same way.

	// Register state.
	logic [31:0]                 timing_reg;
	logic [2:0]                  operating_mode_field;
	can_timing_pkg::event_s      status;
	can_timing_pkg::event_s      mask;
	logic [4:0]                  filter_hold;
	logic [6:0]                  interrupt_cause_code;
	logic                        answered;
	logic [2:0]                  rx_sync;
	logic                        rx_clean;
	logic [1:0]                  samples;
	logic [1:0]                  wake_count;
	logic                        wr_hit;
	logic                        rd_hit;
	logic [6:0]                  next_code;
	logic [3:0]                  ph1;
	logic [3:0]                  ph2;
	logic [3:0]                  auto_ph2;

	// One wait state per access keeps readdata registered.
	// A read loads readdata at the edge that first sees the request, so the
	// word already stands when the master samples waitrequest low.
	// A write commits only at that later edge, where the master takes the
	// answer, so a write is never seen before its transfer is complete.
	assign wr_hit = write && answered;
	assign rd_hit = read && answered == 1'b0;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			answered <= 1'b0;
			waitrequest <= 1'b1;
		end else begin
			answered <= (read || write) && !answered;
			waitrequest <= !((read || write) && !answered);
		end
	end

	// config mode gate: timing writes are dropped outside configuration.
	// A dropped write is still answered normally, so software cannot tell
	// from the bus that it was refused; it must read the register back.
	// Bits outside the write mask stay zero and read as zero.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			timing_reg <= 32'h00000000;
		end else if (wr_hit && address == can_timing_pkg::ADDR_TIMING
			&& operating_mode_field == can_timing_pkg::MODE_CONFIG) begin
			timing_reg <= writedata & can_timing_pkg::TIMING_WMASK;
		end
	end

	// Control register carries the operating mode.
	// Only the mode field is kept; the rest of the control word belongs to
	// other parts of the controller and reads back as zero here.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			operating_mode_field <= can_timing_pkg::MODE_RESET;
		end else if (wr_hit && address == can_timing_pkg::ADDR_CONTROL) begin
			operating_mode_field <=
				writedata[can_timing_pkg::MODE_HI:can_timing_pkg::MODE_LO];
		end
	end

	// Sticky status, write one to clear; a new event wins over the clear.
	// An event pulse in the same cycle as the clear keeps its bit set, so no
	// event is lost when software clears an older one.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			status <= '0;
		end else if (wr_hit && address == can_timing_pkg::ADDR_STATUS) begin
			status <= (status & ~writedata[7:0]) | event_pulse;
		end else begin
			status <= status | event_pulse;
		end
	end

	// Interrupt mask, same layout as status.
	// The four-bit address has no free word for it, so it shares the
	// timing word: its low byte lands here on every write to that word,
	// in any mode. Software must write mask and timing together.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mask <= '0;
		end else if (wr_hit && address == can_timing_pkg::ADDR_MASK) begin
			mask <= writedata[7:0];
		end
	end

	// Level interrupt from any unmasked sticky bit.
	// Registered, so the pin never glitches while status and mask change.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status & mask);
		end
	end

	// phase two length and phase one length, field plus one.
	// The fields are three bits wide, so the lengths run from one to eight
	// quanta and need a fourth bit to hold eight.
	assign ph1 = {1'b0, timing_reg[can_timing_pkg::PH1_HI:
		can_timing_pkg::PH1_LO]} + 4'h1;
	assign ph2 = {1'b0, timing_reg[can_timing_pkg::PH2_HI:
		can_timing_pkg::PH2_LO]} + 4'h1;
	// auto length: the larger of phase one and processing time.
	assign auto_ph2 = (ph1 > can_timing_pkg::IPT_QUANTA) ? ph1
		: can_timing_pkg::IPT_QUANTA;

	// Decoded timing to the bit engine, registered.
	// The bit engine sees the new timing one clock after the register
	// changes; writes are only accepted in configuration mode, when the
	// engine is idle, so this delay is harmless.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			timing <= '0;
		end else begin
			timing.phase_one_length <= ph1;
			timing.phase_two_length <= timing_reg[can_timing_pkg::FREE_BIT]
				? ph2 : auto_ph2;
			timing.propagation_segment <= {1'b0,
				timing_reg[can_timing_pkg::PROP_HI:can_timing_pkg::PROP_LO]}
				+ 4'h1;
			timing.resync_jump_width <=
				timing_reg[can_timing_pkg::SJW_HI:can_timing_pkg::SJW_LO];
			timing.baud_prescaler <=
				timing_reg[can_timing_pkg::BRP_HI:can_timing_pkg::BRP_LO];
			timing.triple_sample_select <=
				timing_reg[can_timing_pkg::TRIPLE_BIT];
			timing.wakeup_line_filter_enable <=
				timing_reg[can_timing_pkg::WAKE_BIT];
		end
	end

	// Bus pin synchroniser; a change counts when stages two and three agree.
	// The line is asynchronous to mclk; the first stage may go metastable
	// and is read by nothing but the second stage.
	// Requiring two stages to agree also drops one-clock spikes.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rx_sync <= 3'h7;
			rx_clean <= 1'b1;
		end else begin
			rx_sync <= {rx_sync[1:0], bus_rx};
			if (rx_sync[1] == rx_sync[2]) begin
				rx_clean <= rx_sync[2];
			end
		end
	end

	// triple sampling: keep the last three samples, vote at the point.
	// The two older samples sit in a short history; the vote is a two of
	// three majority, so one disturbed clock cannot flip the bit.
	// Single sampling takes the line as it stands at the sample point.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			samples <= 2'h3;
			sampled_bit <= 1'b1;
		end else begin
			samples <= {samples[0], rx_clean};
			if (sample_point) begin
				if (timing_reg[can_timing_pkg::TRIPLE_BIT]) begin
					sampled_bit <= (samples[0] & samples[1])
						| (samples[0] & rx_clean) | (samples[1] & rx_clean);
				end else begin
					sampled_bit <= rx_clean;
				end
			end
		end
	end

	// wake filter: a dominant level must hold four clocks to count.
	// Short glitches on a sleeping bus then never wake the controller.
	// With the filter off the cleaned line passes straight through.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wake_count <= 2'h0;
			wake_line <= 1'b1;
		end else if (!timing_reg[can_timing_pkg::WAKE_BIT]) begin
			wake_count <= 2'h0;
			wake_line <= rx_clean;
		end else if (rx_clean) begin
			wake_count <= 2'h0;
			wake_line <= 1'b1;
		end else if (wake_count == 2'h3) begin
			wake_line <= 1'b0;
		end else begin
			wake_count <= wake_count + 2'h1;
		end
	end

	// cause priority: FIFOs first, then the fixed causes.
	// The fixed causes are tried from the bus error down; the FIFO loop
	// runs last and from the top down, so the lowest set FIFO flag wins.
	// Reserved codes are never produced.
	always_comb begin
		next_code = can_timing_pkg::CODE_NONE;
		if (status.bus_error_flag) next_code = can_timing_pkg::CODE_ERROR;
		else if (status.wakeup_flag) next_code = can_timing_pkg::CODE_WAKE;
		else if (status.receive_overflow_flag)
			next_code = can_timing_pkg::CODE_OVERFLOW;
		else if (status.system_error_flag)
			next_code = can_timing_pkg::CODE_ADDR;
		else if (status.bandwidth_error)
			next_code = can_timing_pkg::CODE_BANDW;
		else if (status.timestamp_timer_flag)
			next_code = can_timing_pkg::CODE_TIMER;
		else if (status.mode_change_flag)
			next_code = can_timing_pkg::CODE_MODE;
		else if (status.invalid_message_flag)
			next_code = can_timing_pkg::CODE_INVALID;
		for (int i = FIFOS - 1; i >= 0; i--) begin
			if (fifo_status_flags[i]) next_code = 7'(i);
		end
	end

	// hardware-only vector: filter number held on each match.
	// No bus write reaches this register; the code follows status and the
	// FIFO flags one clock late, and the filter number holds until the
	// next match.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			filter_hold <= 5'h00;
			interrupt_cause_code <= can_timing_pkg::CODE_NONE;
		end else begin
			if (filter_match) filter_hold <= matched_filter_number;
			interrupt_cause_code <= next_code;
		end
	end

	// Read mux; unmapped addresses read zero.
	// The mask shares its address with the timing word, which is decoded
	// first, so reading that address returns the timing word.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			readdata <= 32'h00000000;
		end else if (rd_hit) begin
			if (address == can_timing_pkg::ADDR_TIMING) begin
				readdata <= timing_reg;
			end else if (address == can_timing_pkg::ADDR_VECTOR) begin
				readdata <= {19'h00000, filter_hold, 1'b0,
					interrupt_cause_code};
			end else if (address == can_timing_pkg::ADDR_CONTROL) begin
				readdata <= {8'h00, operating_mode_field, 21'h000000};
			end else if (address == can_timing_pkg::ADDR_STATUS) begin
				readdata <= {24'h000000, status};
			end else if (address == can_timing_pkg::ADDR_MASK) begin
				readdata <= {24'h000000, mask};
			end else begin
				readdata <= 32'h00000000;
			end
		end
	end

endmodule : can_bit_timing_and_vector

// ==== can_timing_assertions.sv ====
// Checker for the CAN bit-timing block, bound to its top-level ports.
// Assumes one clock domain, mclk, with asynchronous active-high rst.
`timescale 1ns/100ps
module can_timing_assertions #(
	parameter int FIFOS = 16
) (
	input wire logic                    mclk,
	input wire logic                    rst,
	input wire logic [3:0]              address,
	input wire logic                    read,
	input wire logic                    write,
	input wire logic [31:0]             writedata,
	input wire logic [31:0]             readdata,
	input wire logic                    waitrequest,
	input wire logic                    bus_rx,
	input wire logic                    sample_point,
	input wire logic [FIFOS-1:0]        fifo_status_flags,
	input wire logic [4:0]              matched_filter_number,
	input wire logic                    filter_match,
	input wire can_timing_pkg::event_s  event_pulse,
	input wire can_timing_pkg::timing_s timing,
	input wire logic                    sampled_bit,
	input wire logic                    wake_line,
	input wire logic                    irq
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	logic cfg_mode;
	logic acc_w;
	logic tw;
	assign acc_w = write && !waitrequest;
	assign tw = acc_w && address == can_timing_pkg::ADDR_TIMING;
	// Mirrors the mode field, so locked timing writes can be judged.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			cfg_mode <= 1'b1;
		else if (acc_w && address == can_timing_pkg::ADDR_CONTROL)
			cfg_mode <= writedata[23:21] == can_timing_pkg::MODE_CONFIG;
	end
	// Phase two: programmed, or the larger of phase one and the IPT.
	function automatic logic [3:0] ph2_exp(input logic [31:0] d);
		logic [3:0] p1;
		p1 = {1'b0, d[13:11]} + 4'h1;
		if (d[15])
			return {1'b0, d[18:16]} + 4'h1;
		return p1 > can_timing_pkg::IPT_QUANTA ? p1 : 4'h2;
	endfunction : ph2_exp
	a_wait_stands: assert property (!waitrequest |=> waitrequest)
		else $error("waitrequest low for more than one cycle");
	a_wait_answers: assert property ((read || write) && waitrequest
		|=> !waitrequest) else $error("request not answered in one cycle");
	a_phase_one: assert property (tw && cfg_mode |-> ##2
		timing.phase_one_length == {1'b0, $past(writedata[13:11], 2)} + 4'h1)
		else $error("phase one length wrong");
	a_phase_two: assert property (tw && cfg_mode |-> ##2
		timing.phase_two_length == ph2_exp($past(writedata, 2)))
		else $error("phase two length wrong");
	a_triple_sel: assert property (tw && cfg_mode |-> ##2
		timing.triple_sample_select == $past(writedata[14], 2))
		else $error("sampling select wrong");
	a_wake_sel: assert property (tw && cfg_mode |-> ##2
		timing.wakeup_line_filter_enable == $past(writedata[22], 2))
		else $error("wake filter enable wrong");
	a_timing_locked: assert property (tw && !cfg_mode |=>
		($stable(timing.phase_one_length) && $stable(timing.phase_two_length))
		[*2]) else $error("timing changed outside configuration mode");
	a_wake_idle: assert property (bus_rx [*8] ##1 bus_rx [*4] |->
		wake_line) else $error("wake line not recessive on idle bus");
	c_cfg_write: cover property (tw && cfg_mode);
	c_lock_write: cover property (tw && !cfg_mode);
	c_irq: cover property ($rose(irq));
endmodule : can_timing_assertions

bind can_bit_timing_and_vector can_timing_assertions #(.FIFOS(FIFOS)) chk_u (
	.mclk(mclk), .rst(rst), .address(address), .read(read), .write(write),
	.writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
	.bus_rx(bus_rx), .sample_point(sample_point),
	.fifo_status_flags(fifo_status_flags), .filter_match(filter_match),
	.matched_filter_number(matched_filter_number), .timing(timing),
	.event_pulse(event_pulse), .sampled_bit(sampled_bit),
	.wake_line(wake_line), .irq(irq));

// ==== can_line_model.sv ====
// Model of the CAN line as seen through the transceiver.
// Assumes the bench commands the level; recessive is the idle level.
`timescale 1ns/100ps
module can_line_model #(
	parameter int BIT_CYCLES = 8
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic drive_dominant,
	output logic     bus_rx,
	output logic     sample_point
);
	int cnt;
	// The line returns to recessive when released, as the bus pulls it.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			bus_rx <= 1'b1;
		else
			bus_rx <= !drive_dominant;
	end
	// One sample-point pulse per nominal bit time.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cnt <= 0;
			sample_point <= 1'b0;
		end else begin
			cnt <= cnt == BIT_CYCLES - 1 ? 0 : cnt + 1;
			sample_point <= cnt == BIT_CYCLES - 1;
		end
	end
endmodule : can_line_model

// ==== tb.sv ====
// Self-checking bench for the CAN bit-timing and vector block.
// Assumes the package, checker and line model are compiled first.
`timescale 1ns/100ps
module tb;
	logic        mclk, rst, read, write, filter_match, dom, waitrequest;
	logic        sampled_bit, wake_line, irq, bus_rx, sample_point;
	logic [3:0]  address;
	logic [31:0] writedata, readdata, wd, exp_q[$], msk_q[$];
	logic [15:0] fifo_status_flags;
	logic [4:0]  matched_filter_number;
	logic [2:0]  p1;
	logic        saw_low;
	can_timing_pkg::event_s  event_pulse;
	can_timing_pkg::timing_s timing;
	int          mismatches, total_checks, cyc;
	can_bit_timing_and_vector dut_u (.mclk(mclk), .rst(rst),
		.address(address), .read(read), .write(write),
		.writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .bus_rx(bus_rx),
		.sample_point(sample_point), .fifo_status_flags(fifo_status_flags),
		.matched_filter_number(matched_filter_number),
		.filter_match(filter_match), .event_pulse(event_pulse),
		.timing(timing), .sampled_bit(sampled_bit),
		.wake_line(wake_line), .irq(irq));
	can_line_model line_u (.mclk(mclk), .rst(rst), .drive_dominant(dom),
		.bus_rx(bus_rx), .sample_point(sample_point));
	// A 100 ns clock.
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task test_done;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done
	// Holds the request until waitrequest is seen low at a rising edge.
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		read <= !w;
		write <= w;
		address <= a;
		writedata <= d;
		@(posedge mclk);
		while (waitrequest !== 1'b0)
			@(posedge mclk);
		read <= 1'b0;
		write <= 1'b0;
	endtask : bus
	task rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
		exp_q.push_back(e & m);
		msk_q.push_back(m);
		repeat (2) @(posedge mclk);
		bus(1'b0, a, 32'h0);
	endtask : rd
	// Compares each read answer with the oldest note; bounds the run.
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc > 5000) begin
			mismatches++;
			test_done();
		end
		if (read === 1'b1 && waitrequest === 1'b0 && exp_q.size() > 0)
			chk("readdata", exp_q.pop_front(), readdata & msk_q.pop_front());
	end
	initial begin
		rst = 1'b1;
		read = 1'b0;
		write = 1'b0;
		address = 4'h0;
		writedata = 32'h0;
		dom = 1'b0;
		filter_match = 1'b0;
		fifo_status_flags = 16'h0;
		matched_filter_number = 5'h0;
		event_pulse = '0;
		void'($urandom(32'h4A2F));
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		rd(can_timing_pkg::ADDR_VECTOR, 32'h40, 32'h1F7F);
		for (int i = 0; i < 6; i++) begin
			p1 = 3'($urandom_range(7, 3));
			wd = {9'h0, 1'($urandom), 3'h0, 3'($urandom_range(p1, 0)), i[0],
				1'($urandom), p1, 3'($urandom_range(7, 1)), 2'h0,
				6'($urandom_range(63, 2))};
			bus(1'b1, can_timing_pkg::ADDR_TIMING, wd);
			rd(can_timing_pkg::ADDR_TIMING, wd, 32'h40FF00);
		end
		bus(1'b1, can_timing_pkg::ADDR_CONTROL, 32'h0);
		bus(1'b1, can_timing_pkg::ADDR_TIMING, ~wd);
		rd(can_timing_pkg::ADDR_TIMING, wd, 32'h407800);
		bus(1'b1, can_timing_pkg::ADDR_CONTROL, 32'h800000);
		$display("test timing done");
		fifo_status_flags <= 16'h0028;
		rd(can_timing_pkg::ADDR_VECTOR, 32'h03, 32'h7F);
		fifo_status_flags <= 16'h8000;
		rd(can_timing_pkg::ADDR_VECTOR, 32'h0F, 32'h7F);
		fifo_status_flags <= 16'h0;
		// Mask bits 0, 2, 5 and 7; the timing half of the word stays legal.
		bus(1'b1, can_timing_pkg::ADDR_MASK, 32'h0007FFA5);
		for (int i = 0; i < 8; i++) begin
			event_pulse <= can_timing_pkg::event_s'(8'h01 << i);
			@(posedge mclk);
			event_pulse <= '0;
			rd(can_timing_pkg::ADDR_VECTOR, 32'h41 + i, 32'h7F);
			chk("irq", 32'((8'hA5 >> i) & 8'h01), {31'h0, irq});
			rd(can_timing_pkg::ADDR_STATUS, 32'h1 << i, 32'hFF);
			bus(1'b1, can_timing_pkg::ADDR_STATUS, 32'h1 << i);
			rd(can_timing_pkg::ADDR_VECTOR, 32'h40, 32'h7F);
			chk("irq", 32'h0, {31'h0, irq});
		end
		matched_filter_number <= 5'h0F;
		filter_match <= 1'b1;
		@(posedge mclk);
		filter_match <= 1'b0;
		bus(1'b1, can_timing_pkg::ADDR_VECTOR, 32'hFFFFFFFF);
		rd(can_timing_pkg::ADDR_VECTOR, 32'h0F40, 32'h1F7F);
		$display("test vector done");
		// A three-clock dominant spike reaches the wake line only unfiltered.
		for (int f = 0; f < 2; f++) begin
			bus(1'b1, can_timing_pkg::ADDR_TIMING, 32'h0007FF02 | (f << 22));
			repeat (8) @(posedge mclk);
			dom <= 1'b1;
			repeat (3) @(posedge mclk);
			dom <= 1'b0;
			saw_low = 1'b0;
			repeat (12) begin
				@(posedge mclk);
				if (wake_line === 1'b0) saw_low = 1'b1;
			end
			chk("wake_spike", {31'h0, f == 0}, {31'h0, saw_low});
		end
		dom <= 1'b1;
		repeat (40) @(posedge mclk);
		chk("line", 32'h0, {30'h0, sampled_bit, wake_line});
		dom <= 1'b0;
		repeat (40) @(posedge mclk);
		chk("line", 32'h3, {30'h0, sampled_bit, wake_line});
		$display("test line done");
		test_done();
	end
endmodule : tb
